// >>> rtl/bus_cond_detect.sv
// Synchronises the bus clock and data pins and finds START and STOP conditions.
// Assumes the pins are asynchronous to core_clk and far slower than it.
`timescale 1ns/1ps
module bus_cond_detect #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic core_clk,   // Core clock.
  input  wire logic rst,        // Asynchronous reset, active high.
  input  wire logic scl_pin,    // Bus clock pin level.
  input  wire logic sda_pin,    // Bus data pin level.
  input  wire logic detect_en,  // Detection allowed.
  output logic      start_p,    // START seen, one cycle.
  output logic      stop_p      // STOP seen, one cycle.
);
  logic [SYNC_STAGES-1:0] scl_sync_r;
  logic [SYNC_STAGES-1:0] sda_sync_r;
  logic                   scl_d_r;
  logic                   sda_d_r;

  initial begin
    if (SYNC_STAGES < 2) $error("bus_cond_detect: SYNC_STAGES must be at least 2");
  end

  // Pins idle high, so the chains reset high to avoid a false condition.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_sync_r <= '1;
      sda_sync_r <= '1;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[SYNC_STAGES-2:0], scl_pin};
      sda_sync_r <= {sda_sync_r[SYNC_STAGES-2:0], sda_pin};
      scl_d_r    <= scl_sync_r[SYNC_STAGES-1];
      sda_d_r    <= sda_sync_r[SYNC_STAGES-1];
    end
  end

  assign start_p = detect_en && scl_d_r && scl_sync_r[SYNC_STAGES-1]
                   && sda_d_r && !sda_sync_r[SYNC_STAGES-1];
  assign stop_p  = detect_en && scl_d_r && scl_sync_r[SYNC_STAGES-1]
                   && !sda_d_r && sda_sync_r[SYNC_STAGES-1];
endmodule

// >>> rtl/event_code_pick.sv
// Picks the highest-priority pending event whose code lies above a floor code.
// Assumes flag n of the pending vector stands for event code n+1.
`timescale 1ns/1ps
module event_code_pick #(
  parameter int NUM_EV = i2c_flags_pkg::NUM_EV
) (
  input  wire logic [NUM_EV-1:0]        pending,  // Pending and enabled events.
  input  wire i2c_flags_pkg::event_code_t floor_code, // Codes at or below are skipped.
  output i2c_flags_pkg::event_code_t    code      // Chosen code, zero if none.
);
  import i2c_flags_pkg::*;

  initial begin
    if (NUM_EV != 7) $error("event_code_pick: NUM_EV must be 7");
  end

  always_comb begin
    code = CODE_NONE;
    for (int i = NUM_EV - 1; i >= 0; i--) begin
      if (pending[i] && (3'(i + 1) > floor_code)) begin
        code = 3'(i + 1);
      end
    end
  end
endmodule

// >>> rtl/i2c_flags_pkg.sv
// Constants, types and register map of the status-flag and interrupt-source block.
// Assumes one core clock domain; bus pins are sampled by that clock.
package i2c_flags_pkg;
  localparam int NUM_EV = 7;

  typedef logic [2:0]  reg_addr_t;
  typedef logic [15:0] reg_data_t;
  typedef logic [2:0]  event_code_t;

  // Register indexes on the plain register port.
  localparam reg_addr_t ADDR_MODE  = 3'h0;
  localparam reg_addr_t ADDR_STAT  = 3'h1;
  localparam reg_addr_t ADDR_ISRC  = 3'h2;
  localparam reg_addr_t ADDR_IEN   = 3'h3;
  localparam reg_addr_t ADDR_ICLR  = 3'h4;

  // Status flag positions; event flag n reports event code n+1, while ST_BB has no code.
  localparam int ST_AL   = 0;
  localparam int ST_NACK = 1;
  localparam int ST_ARDY = 2;
  localparam int ST_RRDY = 3;
  localparam int ST_XRDY = 4;
  localparam int ST_SCD  = 5;
  localparam int ST_AAS  = 6;
  localparam int ST_BB   = 12;

  // Mode control fields.
  localparam int MD_RUN = 5;
  localparam int MD_MST = 10;
  localparam int MD_STP = 11;
  localparam int MD_STT = 13;

  // Interrupt source fields.
  localparam int IS_RW_LSB = 8;
  localparam int IS_RW_MSB = 11;
  localparam reg_data_t RESET_VAL = 16'h0000;

  localparam event_code_t CODE_NONE = 3'h0;
  localparam event_code_t CODE_AL   = 3'h1;
  localparam event_code_t CODE_NACK = 3'h2;
  localparam event_code_t CODE_ARDY = 3'h3;
  localparam event_code_t CODE_RRDY = 3'h4;
  localparam event_code_t CODE_XRDY = 3'h5;
  localparam event_code_t CODE_SCD  = 3'h6;
  localparam event_code_t CODE_AAS  = 3'h7;
endpackage

// >>> rtl/i2c_status_flags_intsrc.sv
// Status flags, interrupt source register and bus-busy tracking of the controller.
// Assumes the shifter gives one-cycle event pulses on core_clk and bus pins are async.
`timescale 1ns/1ps
module i2c_status_flags_intsrc (
  input  wire logic                    core_clk,      // Core clock, 200 MHz.
  input  wire logic                    rst,           // Asynchronous reset, active high.
  input  wire i2c_flags_pkg::reg_addr_t reg_addr,     // Register index.
  input  wire i2c_flags_pkg::reg_data_t reg_wdata,    // Write data.
  input  wire logic                    reg_wr,        // Write strobe.
  input  wire logic                    reg_rd,        // Read strobe.
  input  wire logic                    dbg_access,    // Access comes from the debugger.
  output i2c_flags_pkg::reg_data_t     reg_rdata,     // Read data, cycle after strobe.
  input  wire logic                    scl_pin,       // Bus clock pin.
  input  wire logic                    sda_pin,       // Bus data pin.
  input  wire logic                    tx_ack_p,      // Receiver acknowledged.
  input  wire logic                    tx_nack_p,     // Receiver did not acknowledge.
  input  wire logic                    arb_lost_p,    // Arbitration lost on the bus.
  input  wire logic                    regs_ready_p,  // Registers ready event.
  input  wire logic                    rx_ready_p,    // Receive data ready event.
  input  wire logic                    tx_ready_p,    // Transmit data ready event.
  input  wire logic                    addr_slave_p,  // Addressed as slave event.
  input  wire logic                    gen_call,      // General call transfer active.
  output logic                         module_run,    // Controller out of reset.
  output logic                         master_mode,   // Master mode bit.
  output logic                         stop_request,  // Stop request bit.
  output logic                         start_go,      // Start accepted, one cycle.
  output logic                         bus_busy,      // Bus busy flag.
  output logic                         irq            // Interrupt, level, active high.
);
  import i2c_flags_pkg::*;

  logic [NUM_EV-1:0] flag_r;
  logic [NUM_EV-1:0] flag_nxt;
  logic [NUM_EV-1:0] flag_view;
  logic [NUM_EV-1:0] flag_set;
  logic [NUM_EV-1:0] flag_clr;
  logic [NUM_EV-1:0] ien_r;
  logic [NUM_EV-1:0] pending;
  logic              run_r;
  logic              mst_r;
  logic              stp_r;
  logic              bb_r;
  logic              go_r;
  logic [3:0]        isrc_rw_r;
  event_code_t       code_r;
  event_code_t       code_nxt;
  event_code_t       pick_code;
  event_code_t       pick_floor;
  reg_data_t         rdata_r;
  reg_data_t         rdata_nxt;
  logic              start_p;
  logic              stop_p;
  logic              wr_mode;
  logic              wr_stat;
  logic              wr_clr;
  logic              cpu_isrc_rd;
  logic              start_try;
  logic              busy_start;

  bus_cond_detect #(
    .SYNC_STAGES(2)
  ) u_cond (
    .core_clk  (core_clk),
    .rst       (rst),
    .scl_pin   (scl_pin),
    .sda_pin   (sda_pin),
    .detect_en (run_r),
    .start_p   (start_p),
    .stop_p    (stop_p)
  );

  event_code_pick #(
    .NUM_EV(NUM_EV)
  ) u_pick (
    .pending    (pending),
    .floor_code (pick_floor),
    .code       (pick_code)
  );

  assign wr_mode     = reg_wr && (reg_addr == ADDR_MODE);
  assign wr_stat     = reg_wr && (reg_addr == ADDR_STAT);
  assign wr_clr      = reg_wr && (reg_addr == ADDR_ICLR);
  assign cpu_isrc_rd = reg_rd && (reg_addr == ADDR_ISRC) && !dbg_access;
  assign start_try   = wr_mode && reg_wdata[MD_STT] && reg_wdata[MD_MST] && run_r;
  assign busy_start  = start_try && (bb_r || start_p);

  // Event sources in code order.
  always_comb begin
    flag_set          = '0;
    flag_set[ST_AL]   = arb_lost_p || busy_start;
    flag_set[ST_NACK] = tx_nack_p;
    flag_set[ST_ARDY] = regs_ready_p;
    flag_set[ST_RRDY] = rx_ready_p;
    flag_set[ST_XRDY] = tx_ready_p;
    flag_set[ST_SCD]  = stop_p;
    flag_set[ST_AAS]  = addr_slave_p;
  end

  always_comb begin
    flag_clr = '0;
    if (wr_stat) flag_clr = flag_clr | reg_wdata[NUM_EV-1:0];
    if (wr_clr) flag_clr = flag_clr | reg_wdata[NUM_EV-1:0];
    if (tx_ack_p) flag_clr[ST_NACK] = 1'b1;
    if (cpu_isrc_rd && (code_r == CODE_AL)) flag_clr[ST_AL] = 1'b1;
    if (cpu_isrc_rd && (code_r == CODE_NACK)) flag_clr[ST_NACK] = 1'b1;
    if (cpu_isrc_rd && (code_r == CODE_SCD)) flag_clr[ST_SCD] = 1'b1;
  end

  assign flag_nxt = (flag_r & ~flag_clr) | (flag_set & {NUM_EV{run_r}});

  // Controller reset through the run bit clears every event flag; the bus-busy flag keeps its value.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_r <= '0;
    end else if (!run_r) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_comb begin
    flag_view          = flag_r;
    flag_view[ST_NACK] = flag_r[ST_NACK] || gen_call;
  end

  assign pending = flag_view & ien_r;
  assign irq     = |pending;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ien_r <= '0;
    end else if (reg_wr && (reg_addr == ADDR_IEN)) begin
      ien_r <= reg_wdata[NUM_EV-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
      mst_r <= 1'b0;
      stp_r <= 1'b0;
    end else begin
      if (wr_mode) begin
        run_r <= reg_wdata[MD_RUN];
        mst_r <= reg_wdata[MD_MST];
        stp_r <= reg_wdata[MD_STP];
      end
      if (flag_set[ST_AL] && run_r) begin
        mst_r <= 1'b0;
        stp_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      go_r <= 1'b0;
    end else begin
      // A START seen in the same cycle already makes the bus busy.
      go_r <= start_try && !bb_r && !start_p && !arb_lost_p;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bb_r <= 1'b0;
    end else if (start_p) begin
      bb_r <= 1'b1;
    end else if (stop_p) begin
      bb_r <= 1'b0;
    end
  end

  always_comb begin
    pick_floor = cpu_isrc_rd ? code_r : CODE_NONE;
    if (cpu_isrc_rd || (code_r == CODE_NONE)) begin
      code_nxt = pick_code;
    end else begin
      code_nxt = code_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_r <= CODE_NONE;
    end else if (!run_r) begin
      code_r <= CODE_NONE;
    end else begin
      code_r <= code_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      isrc_rw_r <= RESET_VAL[IS_RW_MSB:IS_RW_LSB];
    end else if (reg_wr && (reg_addr == ADDR_ISRC)) begin
      isrc_rw_r <= reg_wdata[IS_RW_MSB:IS_RW_LSB];
    end
  end

  always_comb begin
    rdata_nxt = RESET_VAL;
    unique case (reg_addr)
      ADDR_MODE: begin
        rdata_nxt[MD_RUN] = run_r;
        rdata_nxt[MD_MST] = mst_r;
        rdata_nxt[MD_STP] = stp_r;
      end
      ADDR_STAT: begin
        rdata_nxt[NUM_EV-1:0] = flag_view;
        rdata_nxt[ST_BB]      = bb_r;
      end
      ADDR_ISRC: begin
        rdata_nxt[IS_RW_MSB:IS_RW_LSB] = isrc_rw_r;
        rdata_nxt[$bits(event_code_t)-1:0] = code_r;
      end
      ADDR_IEN: rdata_nxt[NUM_EV-1:0] = ien_r;
      default: rdata_nxt = RESET_VAL;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= RESET_VAL;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= RESET_VAL;
    end
  end

  assign reg_rdata    = rdata_r;
  assign module_run   = run_r;
  assign master_mode  = mst_r;
  assign stop_request = stp_r;
  assign start_go     = go_r;
  assign bus_busy     = bb_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_start_try_busy;
    start_try && bb_r;
  endsequence

  sequence s_al_cleanup;
    flag_r[ST_AL] && !mst_r && !stp_r;
  endsequence

  a_nack_set_tx: assert property (
    tx_nack_p && run_r && !wr_mode |=> flag_r[ST_NACK])
    else $error("no-acknowledge flag not set after not-acknowledge");

  a_nack_ack_clear: assert property (
    tx_ack_p && !tx_nack_p && run_r && !wr_mode |=> !flag_r[ST_NACK])
    else $error("no-acknowledge flag not cleared by acknowledge");

  a_nack_read_clear: assert property (
    cpu_isrc_rd && code_r == CODE_NACK && !tx_nack_p && !wr_mode |=> !flag_r[ST_NACK])
    else $error("no-acknowledge flag not cleared by source read");

  a_gen_call_view: assert property (
    gen_call && reg_rd && reg_addr == ADDR_STAT |=> reg_rdata[ST_NACK])
    else $error("no-acknowledge does not read set during general call");

  a_al_drop_master: assert property (
    arb_lost_p && run_r && !wr_mode |=> s_al_cleanup)
    else $error("arbitration loss did not clear master and stop bits");

  a_al_busy_start: assert property (
    s_start_try_busy |=> flag_r[ST_AL] && !start_go)
    else $error("start while busy did not flag arbitration lost");

  a_al_read_clear: assert property (
    cpu_isrc_rd && code_r == CODE_AL && !flag_set[ST_AL] && !wr_mode |=> !flag_r[ST_AL])
    else $error("arbitration-lost flag not cleared by source read");

  a_bb_frozen_reset: assert property (
    !run_r |=> $stable(bb_r))
    else $error("bus-busy changed while controller in reset");

  a_bb_start_track: assert property (
    run_r && start_p |=> bb_r ##0 !start_go)
    else $error("bus-busy not set after START");

  a_isrc_zero_bits: assert property (
    reg_rd && reg_addr == ADDR_ISRC |=> reg_rdata[15:12] == 4'h0 && reg_rdata[7:3] == 5'h00)
    else $error("source register reserved bits not zero");

  a_code_lower_next: assert property (
    cpu_isrc_rd && run_r && code_r != CODE_NONE && !wr_mode
      |=> code_r == CODE_NONE || code_r > $past(code_r))
    else $error("code after read not of lower priority");

  a_set_beats_clear: assert property (
    wr_stat && reg_wdata[ST_NACK] && tx_nack_p && run_r && !wr_mode |=> flag_r[ST_NACK])
    else $error("same-cycle set lost against clear");
endmodule

// >>> testbench/bus_partner.sv
// Model of the other masters and slaves sharing the two-wire bus.
// Assumes pull-ups: a released line reads high, and the clock is still between frames.
`timescale 1ns/1ps
module bus_partner #(
  parameter int HALF_NS = 80
) (
  output logic scl,  // Bus clock line.
  output logic sda   // Bus data line.
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Data falls while the clock is high, then a short burst of clock pulses.
  task automatic start_cond;
    #1;
    sda = 1'b0;
    #HALF_NS;
    repeat (2) begin
      scl = 1'b0;
      #HALF_NS;
      scl = 1'b1;
      #HALF_NS;
    end
    scl = 1'b0;
    #HALF_NS;
  endtask

  // Data rises while the clock is high, and both lines are then released.
  task automatic stop_cond;
    #1;
    scl = 1'b0;
    #HALF_NS;
    sda = 1'b0;
    #HALF_NS;
    scl = 1'b1;
    #HALF_NS;
    sda = 1'b1;
    #HALF_NS;
  endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the status-flag and interrupt-source block.
// Assumes the package register map and the bus partner model on the pins.
`timescale 1ns/1ps
module testbench;
  import i2c_flags_pkg::*;
  typedef struct packed {
    logic [6:0]  ev;
    reg_data_t   st;
    event_code_t code;
  } row_t;
  // Event bits: lost, nack, ready, rx, tx, addressed, ack.
  localparam row_t ROWS [6] = '{
    '{7'h01, 16'h0001, CODE_AL}, '{7'h02, 16'h0002, CODE_NACK},
    '{7'h04, 16'h0004, CODE_ARDY}, '{7'h08, 16'h0008, CODE_RRDY},
    '{7'h10, 16'h0010, CODE_XRDY}, '{7'h20, 16'h0040, CODE_AAS}};
  logic       core_clk;
  logic       rst;
  reg_addr_t  reg_addr;
  reg_data_t  reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic       dbg_access;
  reg_data_t  reg_rdata;
  logic       scl;
  logic       sda;
  logic [6:0] ev;
  logic       gen_call;
  logic       module_run;
  logic       master_mode;
  logic       stop_request;
  logic       start_go;
  logic       bus_busy;
  logic       irq;
  int         n_fail = 0;
  int         n_checks = 0;
  int         n_go = 0;
  int         n0;

  bus_partner bus_partner_i (.scl(scl), .sda(sda));

  i2c_status_flags_intsrc i2c_status_flags_intsrc_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .dbg_access(dbg_access), .reg_rdata(reg_rdata),
    .scl_pin(scl), .sda_pin(sda), .tx_ack_p(ev[6]), .tx_nack_p(ev[1]),
    .arb_lost_p(ev[0]), .regs_ready_p(ev[2]), .rx_ready_p(ev[3]), .tx_ready_p(ev[4]),
    .addr_slave_p(ev[5]), .gen_call(gen_call), .module_run(module_run),
    .master_mode(master_mode), .stop_request(stop_request), .start_go(start_go),
    .bus_busy(bus_busy), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (start_go === 1'b1) begin
      n_go++;
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk16(input reg_data_t got, input reg_data_t exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input reg_addr_t a, input reg_data_t d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input reg_addr_t a, input reg_data_t exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk16(reg_rdata, exp);
  endtask

  task automatic pulse(input logic [6:0] e);
    @(posedge core_clk);
    ev <= e;
    @(posedge core_clk);
    ev <= '0;
  endtask

  task automatic wait_busy(input logic exp);
    for (int k = 0; k < 40 && bus_busy !== exp; k++) begin
      @(posedge core_clk);
    end
    chk1(bus_busy, exp);
    if (bus_busy !== exp) begin
      summarize();
    end
  endtask

  task automatic reset_chk;
    for (int a = 0; a < 8; a++) begin
      if (a != 4) begin
        rd(reg_addr_t'(a), '0);
      end
    end
    chk1(irq, 1'b0);
  endtask

  // A start request on an idle bus must be accepted exactly once.
  task automatic go_check;
    n0 = n_go;
    wr(ADDR_MODE, 16'h2420);
    repeat (3) @(posedge core_clk);
    chk1(n_go == n0 + 1, 1'b1);
    rd(ADDR_MODE, 16'h0420);
  endtask

  initial begin
    #400000;
    $display("Error %0t: run timed out", $time);
    n_fail++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dbg_access = 1'b0;
    ev = '0;
    gen_call = 1'b0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    reset_chk();
    $display("test reset values done");
    wr(ADDR_MODE, 16'h0020);
    wr(ADDR_IEN, 16'h007f);
    chk1(module_run, 1'b1);
    wr(ADDR_ISRC, 16'hffff);
    rd(ADDR_ISRC, 16'h0f00);
    wr(ADDR_ISRC, '0);
    foreach (ROWS[i]) begin
      pulse(ROWS[i].ev);
      rd(ADDR_STAT, ROWS[i].st);
      chk1(irq, 1'b1);
      wr(ADDR_ICLR, ROWS[i].st);
      rd(ADDR_ISRC, {13'h0, ROWS[i].code});
      rd(ADDR_ISRC, '0);
      rd(ADDR_STAT, '0);
      chk1(irq, 1'b0);
    end
    $display("test event table done");
    pulse(7'h03);
    dbg_access <= 1'b1;
    rd(ADDR_ISRC, 16'h0001);
    dbg_access <= 1'b0;
    rd(ADDR_STAT, 16'h0003);
    rd(ADDR_ISRC, 16'h0001);
    rd(ADDR_STAT, 16'h0002);
    rd(ADDR_ISRC, 16'h0002);
    rd(ADDR_STAT, '0);
    rd(ADDR_ISRC, '0);
    $display("test clear on read done");
    pulse(7'h02);
    pulse(7'h40);
    rd(ADDR_STAT, '0);
    @(posedge core_clk);
    reg_addr <= ADDR_STAT;
    reg_wdata <= 16'h0002;
    reg_wr <= 1'b1;
    ev <= 7'h02;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    ev <= '0;
    rd(ADDR_STAT, 16'h0002);
    wr(ADDR_STAT, 16'h0002);
    rd(ADDR_STAT, '0);
    gen_call <= 1'b1;
    rd(ADDR_STAT, 16'h0002);
    chk1(irq, 1'b1);
    gen_call <= 1'b0;
    wr(ADDR_IEN, '0);
    pulse(7'h04);
    #1 chk1(irq, 1'b0);
    wr(ADDR_IEN, 16'h007f);
    #1 chk1(irq, 1'b1);
    wr(ADDR_ICLR, 16'h0004);
    #1 chk1(irq, 1'b0);
    wr(ADDR_MODE, '0);
    wr(ADDR_MODE, 16'h0020);
    rd(ADDR_ISRC, '0);
    $display("test flag clearing done");
    wr(ADDR_MODE, 16'h0c20);
    rd(ADDR_MODE, 16'h0c20);
    pulse(7'h01);
    rd(ADDR_MODE, 16'h0020);
    chk1(master_mode | stop_request, 1'b0);
    rd(ADDR_STAT, 16'h0001);
    rd(ADDR_ISRC, 16'h0001);
    rd(ADDR_STAT, '0);
    bus_partner_i.start_cond();
    wait_busy(1'b1);
    n0 = n_go;
    wr(ADDR_MODE, 16'h2420);
    rd(ADDR_STAT, 16'h1001);
    chk1(n_go == n0, 1'b1);
    rd(ADDR_MODE, 16'h0020);
    rd(ADDR_ISRC, 16'h0001);
    $display("test arbitration done");
    wr(ADDR_MODE, '0);
    bus_partner_i.stop_cond();
    chk1(bus_busy, 1'b1);
    rd(ADDR_STAT, 16'h1000);
    wr(ADDR_MODE, 16'h0020);
    repeat (40) @(posedge core_clk);
    chk1(bus_busy, 1'b1);
    bus_partner_i.stop_cond();
    wait_busy(1'b0);
    rd(ADDR_STAT, 16'h0020);
    rd(ADDR_ISRC, 16'h0006);
    rd(ADDR_STAT, '0);
    go_check();
    $display("test bus busy done");
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    reset_chk();
    wr(ADDR_MODE, 16'h0020);
    repeat (40) @(posedge core_clk);
    chk1(bus_busy, 1'b0);
    go_check();
    $display("test second reset done");
    summarize();
  end
endmodule
